// ---- design/hbwm_pkg.sv ----
// Constants shared by the host bus word address map and its register bank
// Function
// - With neither serial-memory strap pulled up at reset, the word-addressed host bus setting is used.
// - Two packet data ports exist: the programmed-I/O port at offset 10h and the window port.
// - Single reads and single writes work at both data ports.
// - Burst reads return consecutive packet words although the host address steps every beat.
// - Even host addresses 0 to 3E map to offsets 0 to 1F, offset being address halved, bit 0 ignored.
// - A register read at offset n gives byte n on the low lane and byte n with bit 0 set on the high.
// - A register write at offset n stores only the low lane byte; the high lane is ignored.
// - Host address 20 reaches the data port; host address 22 (offset 11) is undefined.
// - Address 3C reads offset 1E on the low lane only; a read at 3E starts the reset action.
// - Host addresses 40 to 7FF are unused; 800 to FFF all reach the data port.
// - Bit 4 of the power management register, page 3 offset 0Bh, set to 1 puts the regulator in standby.
package hbwm_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [4:0] HBWM_OFS_PAGE_SEL = 5'h00;
  localparam logic [4:0] HBWM_OFS_PMR = 5'h0b;
  localparam logic [4:0] HBWM_OFS_DATA_PORT = 5'h10;
  localparam logic [4:0] HBWM_OFS_UNDEF = 5'h11;
  localparam logic [4:0] HBWM_OFS_LOW_ONLY = 5'h1e;
  localparam logic [4:0] HBWM_OFS_RESET = 5'h1f;

  // ==========================================================================
  // Host address map
  localparam int HBWM_HOST_ADDR_W = 12;
  localparam logic [11:0] HBWM_REG_LIMIT = 12'h040;
  localparam int HBWM_WIN_BIT = 11;

  // ==========================================================================
  // Field positions and reset values
  localparam int HBWM_PAGE_LSB = 6;
  localparam logic [1:0] HBWM_PMR_PAGE = 2'h3;
  localparam int HBWM_REGULATOR_STANDBY_BIT_BIT = 4;
  localparam logic [7:0] HBWM_CSR_RESET = 8'h00;
  localparam logic [7:0] HBWM_PMR_RESET = 8'h00;
  localparam logic [15:0] HBWM_RDATA_RESET = 16'h0000;

  // ==========================================================================
  // Counts
  localparam int HBWM_CSR_COUNT = 32;
  localparam logic [3:0] HBWM_RESET_ACT_CYCLES = 4'h8;

  // Host cycle sequencer states
  typedef enum logic [1:0] {
    HBWM_IDLE = 2'b00,
    HBWM_READ = 2'b01,
    HBWM_WRITE = 2'b10
  } hbwm_state_t;

endpackage

// ---- design/hbwm_csr_bank.sv ----
// Byte-wide control/status register bank with a paired read port
`timescale 1ns/100ps
module hbwm_csr_bank #(
  parameter int COUNT = 32
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic clear_in,
  input wire logic wr_en_in,
  input wire logic [4:0] wr_ofs_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic [4:0] rd_ofs_in,
  output logic [7:0] rd_lo_out,
  output logic [7:0] rd_hi_out,
  output logic [1:0] page_out
);

  logic [7:0] bank [COUNT];

  // ==========================================================================
  // Storage, one flop group per entry
  genvar i;
  generate
    for (i = 0; i < COUNT; i++) begin : g_entry
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          bank[i] <= hbwm_pkg::HBWM_CSR_RESET;
        end else if (ce_in) begin
          if (clear_in) begin
            bank[i] <= hbwm_pkg::HBWM_CSR_RESET;
          end else if (wr_en_in && (wr_ofs_in == 5'(i))) begin
            bank[i] <= wr_byte_in; // Low lane only
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Paired read: byte n and byte n with bit 0 forced high
  assign rd_lo_out = bank[rd_ofs_in];
  assign rd_hi_out = bank[{rd_ofs_in[4:1], 1'b1}];
  assign page_out = bank[hbwm_pkg::HBWM_OFS_PAGE_SEL][hbwm_pkg::HBWM_PAGE_LSB +: 2];

endmodule // hbwm_csr_bank

// ---- design/hbwm_top.sv ----
// Host bus word address map: pin sampling, decode, lane steering, data ports
`timescale 1ns/100ps
module hbwm_top #(
  parameter int ADDR_W = 12,
  parameter int WIN_BIT = 11,
  parameter int PKT_WORDS = 256,
  parameter int PTR_W = 8
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic serial_mem_select_strap_in,
  input wire logic serial_mem_clock_strap_in,
  input wire logic host_cs_n_in,
  input wire logic host_rd_n_in,
  input wire logic host_wr_n_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic [15:0] host_data_lanes_in,
  output logic [15:0] host_data_lanes_out,
  output logic host_data_lanes_oe_out,
  output logic word_mode_out,
  output logic regulator_standby_out,
  output logic soft_reset_out,
  output logic unmapped_access_out,
  output logic [PTR_W-1:0] buffer_ptr_out
);

  // ==========================================================================
  // Pin synchronisers, two flops each
  logic [ADDR_W+20:0] pins_s1;
  logic [ADDR_W+20:0] pins_s2;

  // Every host pin is asynchronous to mclk_in
  // No reset here: the straps must travel through both stages while reset is held,
  // otherwise the capture after release sees a forced level instead of the pins
  always_ff @(posedge mclk_in) begin
    if (ce_in) begin
      pins_s1 <= {serial_mem_select_strap_in, serial_mem_clock_strap_in, host_cs_n_in,
                  host_rd_n_in, host_wr_n_in, host_addr_in, host_data_lanes_in};
      pins_s2 <= pins_s1;
    end
  end

  logic sel_strap_s;
  logic clk_strap_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [15:0] data_s;

  // Split the second stage only
  assign {sel_strap_s, clk_strap_s, cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pins_s2;

  // ==========================================================================
  // Strap capture
  logic strap_seen;
  logic word_mode;

  // Straps are caught in the first enabled cycle after reset is released; a pulled-up strap picks another setting
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      strap_seen <= 1'b0;
      word_mode <= 1'b0;
    end else if (ce_in && !strap_seen) begin
      strap_seen <= 1'b1;
      word_mode <= !sel_strap_s && !clk_strap_s;
    end
  end

  assign word_mode_out = word_mode;

  // ==========================================================================
  // Strobe edges
  logic rd_act;
  logic wr_act;
  logic rd_prev;
  logic wr_prev;
  logic rd_start;
  logic wr_end;
  logic busy;

  // Accesses are ignored until the strap is known and while reset action runs
  assign rd_act = !cs_n_s && !rd_n_s && word_mode && !busy;
  assign wr_act = !cs_n_s && !wr_n_s && word_mode && !busy;

  // Previous strobe levels
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else if (ce_in) begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  // Read acts at its start, write at its end so the data has settled
  assign rd_start = ce_in && rd_act && !rd_prev;
  assign wr_end = ce_in && !wr_act && wr_prev;

  // ==========================================================================
  // Write capture: address at start, data every cycle of the strobe
  logic [ADDR_W-1:0] wr_addr;
  logic [15:0] wr_data;

  // Last sampled data before the strobe rises is what gets stored
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_addr <= '0;
      wr_data <= '0;
    end else if (ce_in && wr_act) begin
      if (!wr_prev) begin
        wr_addr <= addr_s;
      end
      wr_data <= data_s;
    end
  end

  // ==========================================================================
  // Address decode, shared by both directions
  logic [ADDR_W-1:0] dec_addr;
  logic in_window;
  logic in_regs;
  logic [4:0] dec_ofs;
  logic hit_port;
  logic hit_undef;
  logic hit_unused;

  assign dec_addr = rd_start ? addr_s : wr_addr;
  // The pin tied to host line WIN_BIT opens the window; no low bit matters there
  assign in_window = dec_addr[WIN_BIT];
  assign in_regs = !in_window && (dec_addr < ADDR_W'(hbwm_pkg::HBWM_REG_LIMIT));
  assign dec_ofs = dec_addr[5:1]; // Bit 0 ignored
  assign hit_port = in_window || (in_regs && (dec_ofs == hbwm_pkg::HBWM_OFS_DATA_PORT));
  assign hit_undef = in_regs && (dec_ofs == hbwm_pkg::HBWM_OFS_UNDEF);
  assign hit_unused = !in_window && !in_regs;

  // ==========================================================================
  // Register bank and power management register
  logic csr_wr;
  logic csr_clear;
  logic [7:0] csr_lo;
  logic [7:0] csr_hi;
  logic [1:0] page;
  logic pmr_sel;
  logic [7:0] power_management;

  // Offset 0Bh on page 3 is the power register, not a bank byte
  assign pmr_sel = (page == hbwm_pkg::HBWM_PMR_PAGE) && (dec_ofs == hbwm_pkg::HBWM_OFS_PMR);
  assign csr_wr = wr_end && in_regs && !hit_port && !hit_undef && !pmr_sel;

  hbwm_csr_bank #(
    .COUNT(hbwm_pkg::HBWM_CSR_COUNT)
  ) u_bank (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .clear_in(csr_clear),
    .wr_en_in(csr_wr),
    .wr_ofs_in(dec_ofs),
    .wr_byte_in(wr_data[7:0]),
    .rd_ofs_in(dec_ofs),
    .rd_lo_out(csr_lo),
    .rd_hi_out(csr_hi),
    .page_out(page)
  );

  // Power register takes the low lane only
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      power_management <= hbwm_pkg::HBWM_PMR_RESET;
    end else if (ce_in) begin
      if (csr_clear) begin
        power_management <= hbwm_pkg::HBWM_PMR_RESET;
      end else if (wr_end && in_regs && pmr_sel) begin
        power_management <= wr_data[7:0];
      end
    end
  end

  assign regulator_standby_out = power_management[hbwm_pkg::HBWM_REGULATOR_STANDBY_BIT_BIT];

  // ==========================================================================
  // Reset action started by a read at the last offset
  logic rst_hit;
  logic [3:0] rst_cnt;

  assign rst_hit = rd_start && in_regs && (dec_ofs == hbwm_pkg::HBWM_OFS_RESET);
  assign csr_clear = rst_hit;
  assign busy = (rst_cnt != 4'h0);

  // Holds off the host for a fixed count so the clear is seen everywhere
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rst_cnt <= 4'h0;
    end else if (ce_in) begin
      if (rst_hit) begin
        rst_cnt <= hbwm_pkg::HBWM_RESET_ACT_CYCLES;
      end else if (busy) begin
        rst_cnt <= rst_cnt - 4'h1;
      end
    end
  end

  assign soft_reset_out = busy;

  // ==========================================================================
  // Packet word store behind both data ports
  logic [15:0] pkt_mem [PKT_WORDS];
  logic [PTR_W-1:0] ptr;
  logic port_rd;
  logic port_wr;

  assign port_rd = rd_start && hit_port;
  assign port_wr = wr_end && hit_port;

  // Whole word stored, both lanes count at the data port
  always_ff @(posedge mclk_in) begin
    if (ce_in && port_wr) begin
      pkt_mem[ptr] <= wr_data;
    end
  end

  // One step per access, whatever window address the host used
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ptr <= '0;
    end else if (ce_in) begin
      if (rst_hit) begin
        ptr <= '0;
      end else if (port_rd || port_wr) begin
        ptr <= ptr + PTR_W'(1);
      end
    end
  end

  assign buffer_ptr_out = ptr;

  // ==========================================================================
  // Read lane steering
  logic [15:0] next_rdata;

  // Register, port, low-only and dead addresses each shape the lanes
  always_comb begin
    next_rdata = hbwm_pkg::HBWM_RDATA_RESET;
    if (hit_port) begin
      next_rdata = pkt_mem[ptr];
    end else if (in_regs) begin
      if (dec_ofs == hbwm_pkg::HBWM_OFS_LOW_ONLY) begin
        next_rdata = {8'h00, csr_lo};
      end else if (dec_ofs == hbwm_pkg::HBWM_OFS_RESET || hit_undef) begin
        next_rdata = hbwm_pkg::HBWM_RDATA_RESET;
      end else if (pmr_sel) begin
        // Offset 0Bh already has bit 0 set, so both lanes carry the power register
        next_rdata = {power_management, power_management};
      end else if ((page == hbwm_pkg::HBWM_PMR_PAGE) &&
                   ({dec_ofs[4:1], 1'b1} == hbwm_pkg::HBWM_OFS_PMR)) begin
        next_rdata = {power_management, csr_lo};
      end else begin
        next_rdata = {csr_hi, csr_lo};
      end
    end
  end

  // ==========================================================================
  // Read data and lane enable
  logic [15:0] rdata;
  logic oe;

  // Data frozen at strobe start so a burst beat sees one stable word
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata <= hbwm_pkg::HBWM_RDATA_RESET;
    end else if (rd_start) begin
      rdata <= next_rdata;
    end
  end

  // Drive only while the host holds its read strobe
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      oe <= 1'b0;
    end else if (ce_in) begin
      oe <= rd_act;
    end
  end

  assign host_data_lanes_out = rdata;
  assign host_data_lanes_oe_out = oe;

  // ==========================================================================
  // Unused and undefined access flag, one cycle per access
  logic unmapped;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      unmapped <= 1'b0;
    end else if (ce_in) begin
      unmapped <= (rd_start || wr_end) && (hit_unused || hit_undef);
    end
  end

  assign unmapped_access_out = unmapped;

endmodule // hbwm_top

// ---- dv/hbwm_checker.sv ----
// Concurrent checks on the host port of the word address map
`timescale 1ns/100ps
module hbwm_checker #(
  parameter int ADDR_W = 12,
  parameter int PTR_W = 8
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic host_cs_n_in,
  input wire logic host_rd_n_in,
  input wire logic host_wr_n_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic [15:0] host_data_lanes_out,
  input wire logic host_data_lanes_oe_out,
  input wire logic word_mode_out,
  input wire logic regulator_standby_out,
  input wire logic soft_reset_out,
  input wire logic unmapped_access_out,
  input wire logic [PTR_W-1:0] buffer_ptr_out
);
  // ==========================================================================
  // Clocking
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // Reset action: caused by a read at 3E, then eight cycles high
  sequence s_read_3e;
    $past(host_addr_in, 2) == ADDR_W'(12'h03e) && $past(!host_rd_n_in, 2);
  endsequence
  sequence s_hold8;
    soft_reset_out [*8] ##1 !soft_reset_out;
  endsequence

  // ==========================================================================
  // Properties
  a_reset_act_len: assert property ($rose(soft_reset_out) |-> s_read_3e ##0 s_hold8)
    else $error("reset action cause or length wrong");
  a_unmapped_pulse: assert property (unmapped_access_out |=> !unmapped_access_out)
    else $error("unmapped pulse longer than one cycle");
  a_ptr_step: assert property (!$stable(buffer_ptr_out) |->
    buffer_ptr_out == PTR_W'($past(buffer_ptr_out) + 1'b1) ||
    (buffer_ptr_out == '0 && (soft_reset_out || $past(soft_reset_out))))
    else $error("pointer moved by other than one");
  a_oe_cause: assert property ($rose(host_data_lanes_oe_out) |->
    $past(!host_rd_n_in && !host_cs_n_in, 2) && word_mode_out)
    else $error("lanes driven without a read");
  a_oe_release: assert property ($rose(host_rd_n_in) |-> ##[1:4] !host_data_lanes_oe_out)
    else $error("lanes still driven after read end");
  a_lanes_hold: assert property (
    host_data_lanes_oe_out && $past(host_data_lanes_oe_out) |-> $stable(host_data_lanes_out))
    else $error("read word changed while driven");
  a_mode_fixed: assert property (!$past(reset_in) && !$past(reset_in, 2) |-> $stable(word_mode_out))
    else $error("bus setting changed outside reset");
  a_off_silent: assert property (!word_mode_out |-> !host_data_lanes_oe_out && !unmapped_access_out)
    else $error("host served in the wrong bus setting");
  a_standby_set: assert property ($rose(regulator_standby_out) |->
    word_mode_out && !soft_reset_out && $past(host_wr_n_in))
    else $error("standby set without a finished write");
endmodule // hbwm_checker

bind hbwm_top hbwm_checker #(.ADDR_W(ADDR_W), .PTR_W(PTR_W)) hbwm_checker_inst (
  .mclk_in(mclk_in), .reset_in(reset_in), .host_cs_n_in(host_cs_n_in),
  .host_rd_n_in(host_rd_n_in), .host_wr_n_in(host_wr_n_in), .host_addr_in(host_addr_in),
  .host_data_lanes_out(host_data_lanes_out), .host_data_lanes_oe_out(host_data_lanes_oe_out),
  .word_mode_out(word_mode_out), .regulator_standby_out(regulator_standby_out),
  .soft_reset_out(soft_reset_out), .unmapped_access_out(unmapped_access_out),
  .buffer_ptr_out(buffer_ptr_out)
);

// ---- dv/hbwm_host_model.sv ----
// Host processor model driving the word-addressed host pins
`timescale 1ns/100ps
module hbwm_host_model (
  input wire logic mclk_in,
  input wire logic [15:0] host_data_lanes_in,
  output logic host_cs_n_out,
  output logic host_rd_n_out,
  output logic host_wr_n_out,
  output logic [11:0] host_addr_out,
  output logic [15:0] host_data_lanes_out
);
  // Idle pins at time zero
  initial begin
    host_cs_n_out = 1'b1;
    host_rd_n_out = 1'b1;
    host_wr_n_out = 1'b1;
    host_addr_out = 12'h000;
    host_data_lanes_out = 16'h0000;
  end

  // One single access; six cycles each way clears the two-stage sync
  task automatic host_cycle(input logic [11:0] a, input logic [15:0] d, input logic wr,
                            output logic [15:0] q);
    @(negedge mclk_in);
    host_addr_out = a; // A11 is the window select
    if (wr) begin
      host_data_lanes_out = d;
    end
    host_cs_n_out = 1'b0;
    host_rd_n_out = wr;
    host_wr_n_out = !wr;
    repeat (6) @(negedge mclk_in);
    q = host_data_lanes_in;
    host_cs_n_out = 1'b1;
    host_rd_n_out = 1'b1;
    host_wr_n_out = 1'b1;
    // Released lanes show no stale word
    host_data_lanes_out = ~host_data_lanes_out;
    repeat (6) @(negedge mclk_in);
  endtask
endmodule // hbwm_host_model

// ---- dv/hbwm_bench.sv ----
// Self-checking bench for the host bus word address map
`timescale 1ns/100ps
module hbwm_bench;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] strap = 2'b00;
  logic cs_n, rd_n, wr_n, oe, mode, stby, srst, unm;
  logic [11:0] addr;
  logic [15:0] wdata, lanes, got;
  logic [7:0] ptr;
  int error_cnt = 0;
  int tests_run = 0;
  int unm_cnt = 0;
  int oe_cnt = 0;
  int oe_base = 0;

  // ==========================================================================
  // Clock, design and host
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  hbwm_top hbwm_top_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(1'b1),
    .serial_mem_select_strap_in(strap[1]), .serial_mem_clock_strap_in(strap[0]),
    .host_cs_n_in(cs_n), .host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .host_addr_in(addr),
    .host_data_lanes_in(wdata), .host_data_lanes_out(lanes), .host_data_lanes_oe_out(oe),
    .word_mode_out(mode), .regulator_standby_out(stby), .soft_reset_out(srst),
    .unmapped_access_out(unm), .buffer_ptr_out(ptr)
  );
  hbwm_host_model hbwm_host_model_inst (
    .mclk_in(mclk_in), .host_data_lanes_in(lanes), .host_cs_n_out(cs_n),
    .host_rd_n_out(rd_n), .host_wr_n_out(wr_n), .host_addr_out(addr),
    .host_data_lanes_out(wdata)
  );
  // Unmapped pulses and driven-lane cycles seen so far
  always @(posedge mclk_in) begin
    if (unm === 1'b1) begin
      unm_cnt++;
    end
    if (oe === 1'b1) begin
      oe_cnt++;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    hbwm_host_model_inst.host_cycle(a, 16'h0000, 1'b0, got);
    chk(got, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    hbwm_host_model_inst.host_cycle(a, d, 1'b1, got);
  endtask
  // Straps settle while reset is held
  task automatic do_reset(input logic [1:0] s);
    @(negedge mclk_in);
    strap = s;
    reset_in = 1'b1;
    repeat (16) @(negedge mclk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded wait for the reset action to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (srst !== 1'b0 && n < 40) begin
      @(negedge mclk_in);
      n++;
    end
    if (srst !== 1'b0) begin
      error_cnt++;
      conclude();
    end
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    do_reset(2'b00);
    chk({15'h0, mode}, 16'h0001);
    chk({15'h0, stby}, 16'h0000);
    // High lane carries junk that must be dropped
    wr(12'h004, 16'heea5);
    wr(12'h006, 16'hee3c);
    wr(12'h03c, 16'hee5a);
    oe_base = oe_cnt;
    rd(12'h004, 16'h3ca5);
    chk(16'(oe_cnt - oe_base), 16'h0006);
    rd(12'h005, 16'h3ca5);
    rd(12'h006, 16'h3c3c);
    rd(12'h03c, 16'h005a);
    // Power register sits on page 3
    wr(12'h000, 16'h00c0);
    wr(12'h016, 16'hff10);
    chk({15'h0, stby}, 16'h0001);
    rd(12'h016, 16'h1010);
    rd(12'h014, 16'h1000);
    wr(12'h016, 16'h0000);
    chk({15'h0, stby}, 16'h0000);
    wr(12'h000, 16'h0000);
    // Both data ports share one pointer
    wr(12'h020, 16'h1234);
    wr(12'h800, 16'h5678);
    wr(12'hffe, 16'h9abc);
    chk({8'h00, ptr}, 16'h0003);
    rd(12'h03e, 16'h0000);
    wait_idle();
    chk({8'h00, ptr}, 16'h0000);
    rd(12'h004, 16'h0000);
    // Host address steps every beat, words stay in order
    rd(12'h800, 16'h1234);
    rd(12'h802, 16'h5678);
    rd(12'h804, 16'h9abc);
    rd(12'h040, 16'h0000);
    wr(12'h7fe, 16'h4321);
    rd(12'h022, 16'h0000);
    chk(16'(unm_cnt), 16'h0003);
    chk({8'h00, ptr}, 16'h0003);
    // Either strap pulled up leaves the host unserved
    for (int k = 1; k < 3; k++) begin
      do_reset(2'(k));
      chk({15'h0, mode}, 16'h0000);
      oe_base = oe_cnt;
      rd(12'h004, 16'h0000);
      chk(16'(oe_cnt - oe_base), 16'h0000);
    end
    conclude();
  end
endmodule // hbwm_bench
